// ---- rtl/strap_map.svh ----
// Register offsets, field positions and reset values of the strap block
`ifndef STRAP_MAP_SVH
`define STRAP_MAP_SVH

`define STRAP_ADDR_W 4
`define STRAP_OFF_STATUS 4'h0
`define STRAP_OFF_BOOT 4'h4
`define STRAP_OFF_VSEL 4'h8
`define STRAP_OFF_PINCTL 4'hC

// Strap status fields
`define STRAP_BIT_BOOT 0
`define STRAP_BIT_SUPPLY 1
`define STRAP_BIT_PRINT 2

// Boot status fields
`define BOOT_FLD_MODE_LO 0
`define BOOT_FLD_MODE_HI 1
`define BOOT_BIT_PRINT_EN 2
`define BOOT_BIT_ALT_PIN 3
`define BOOT_BIT_FLASH_1V8 4

// Supply override fields
`define VSEL_BIT_OVR_EN 0
`define VSEL_BIT_OVR_1V8 1

// Pin control fields: outputs [2:0], enables [6:4]
`define PINCTL_OUT_LO 0
`define PINCTL_OE_LO 4

// Weak pull levels of boot, supply and print pins
`define STRAP_DFLT_BOOT 1'b1
`define STRAP_DFLT_SUPPLY 1'b0
`define STRAP_DFLT_PRINT 1'b0

`define VSEL_RESET 2'b00
`define PINCTL_RESET 8'h00

`define AXI_RESP_OKAY 2'b00
`define AXI_RESP_SLVERR 2'b10

`endif

// ---- rtl/strap_pkg.sv ----
// Types shared by the strap latch block
package strap_pkg;

    typedef struct packed {
        logic print_sel;
        logic supply_sel;
        logic boot_sel;
    } strap_bits_type;

    typedef enum logic [1:0] {
        BOOT_FLASH = 2'b00,
        BOOT_DOWNLOAD = 2'b01,
        BOOT_ILLEGAL = 2'b10
    } boot_mode_type;

    typedef struct packed {
        logic [1:0] print_ctrl;
        logic alt_print_pin;
    } fuse_type;

endpackage

// ---- rtl/strap_latch_cell.sv ----
// One strap latch: samples a pin during system reset, then holds
`timescale 1ns/1ps
module strap_latch_cell #(
    parameter logic PULL_LEVEL = 1'b0
) (
    input wire logic clk_sys,
    input wire logic arst_n,
    input wire logic sys_reset_active,
    input wire logic pin_in,
    input wire logic pin_driven,
    output logic strap_bit
);

    logic bit_reg;
    logic bit_next;

    always_comb begin
        bit_next = bit_reg;
        if (sys_reset_active) begin
            // Undriven pin resolves to the weak pull level
            bit_next = pin_driven ? pin_in : PULL_LEVEL; // RULE_03 RULE_06
        end
    end

    // Power-down reloads the pull level; otherwise the latch changes only during system reset
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            bit_reg <= PULL_LEVEL;
        end else begin
            bit_reg <= bit_next; // RULE_04
        end
    end

    assign strap_bit = bit_reg;

endmodule

// ---- rtl/strap_pin_latch_boot_select.sv ----
// Strap pin latch with boot decode, print gating and AXI4-Lite registers
`timescale 1ns/1ps
`include "strap_map.svh"

// Functional notes
// RULE_01: There are exactly three strap inputs: boot select, supply select and print select.
// RULE_02: Software reads the held strap bits through a read-only status register.
// RULE_03: While any system reset is active each strap pin is sampled into a latch as 0 or 1.
// RULE_04: Latched strap bits are held until power-down and are not re-sampled on other events.
// RULE_05: After reset release the strap pins return to normal I/O and cannot change the latched bits.
// RULE_06: An undriven strap pin takes its weak pull: boot select 1, supply select 0, print select 0.
// RULE_07: The outside party holds each pin at its wanted level for the whole power-on reset.
// RULE_08: Boot select 1 gives flash boot; boot select 0 with print select 0 gives download boot.
// RULE_09: The outside party never presents print select high with boot select low.
// RULE_10: Supply select 0 gives 3.3 V flash supply, 1 gives 1.8 V; firmware may override after boot.
// RULE_11: The outside party does not pull supply select high at power-on.
// RULE_12: Boot messages go to the primary serial pin unless a fused bit moves them to the alternate pin.
// RULE_13: The two-bit fused print field: 0 prints, 1 prints if print select 0, 2 if 1, 3 never.
// RULE_14: Strap bits sit at fixed positions of the status register and unused bits read zero.
module strap_pin_latch_boot_select
    import strap_pkg::*;
#(
    parameter int NUM_STRAPS = 3
) (
    input wire logic clk_sys,
    input wire logic arst_n,
    input wire logic sys_reset_active,
    input wire logic boot_select_pin_in,
    input wire logic boot_select_pin_driven,
    output logic boot_select_pin_out,
    output logic boot_select_pin_oe,
    input wire logic supply_select_pin_in,
    input wire logic supply_select_pin_driven,
    output logic supply_select_pin_out,
    output logic supply_select_pin_oe,
    input wire logic print_select_pin_in,
    input wire logic print_select_pin_driven,
    output logic print_select_pin_out,
    output logic print_select_pin_oe,
    input wire fuse_type fuse,
    input wire logic boot_msg_tx,
    output logic primary_serial_tx_pin,
    output logic alt_serial_tx_pin,
    output boot_mode_type boot_mode,
    output logic boot_print_en,
    output logic flash_supply_1v8,
    input wire logic [`STRAP_ADDR_W-1:0] s_axi_awaddr,
    input wire logic [2:0] s_axi_awprot,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [`STRAP_ADDR_W-1:0] s_axi_araddr,
    input wire logic [2:0] s_axi_arprot,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready
);

    if (NUM_STRAPS != 3) begin : g_bad_count
        $error("strap block serves exactly three strap pins");
    end

    function automatic boot_mode_type decode_mode(input strap_bits_type s);
        if (s.boot_sel) begin
            decode_mode = BOOT_FLASH; // RULE_08
        end else if (!s.print_sel) begin
            decode_mode = BOOT_DOWNLOAD; // RULE_08
        end else begin
            decode_mode = BOOT_ILLEGAL;
        end
    endfunction

    function automatic logic print_gate(input logic [1:0] ctrl, input logic psel);
        unique case (ctrl)
            2'b00: print_gate = 1'b1; // RULE_13
            2'b01: print_gate = !psel; // RULE_13
            2'b10: print_gate = psel; // RULE_13
            2'b11: print_gate = 1'b0; // RULE_13
        endcase
    endfunction

    function automatic logic addr_mapped(input logic [`STRAP_ADDR_W-1:0] a);
        addr_mapped = (a == `STRAP_OFF_STATUS) || (a == `STRAP_OFF_BOOT) ||
                      (a == `STRAP_OFF_VSEL) || (a == `STRAP_OFF_PINCTL);
    endfunction

    // Strap latches
    logic [NUM_STRAPS-1:0] pin_level;
    logic [NUM_STRAPS-1:0] pin_driven;
    logic [NUM_STRAPS-1:0] strap_vec;
    strap_bits_type straps;
    localparam logic [NUM_STRAPS-1:0] PULL_LEVELS = {`STRAP_DFLT_PRINT, `STRAP_DFLT_SUPPLY, `STRAP_DFLT_BOOT};

    assign pin_level = {print_select_pin_in, supply_select_pin_in, boot_select_pin_in}; // RULE_01
    assign pin_driven = {print_select_pin_driven, supply_select_pin_driven, boot_select_pin_driven};
    assign straps = strap_bits_type'(strap_vec);

    genvar gi;
    generate
        for (gi = 0; gi < NUM_STRAPS; gi++) begin : g_strap
            strap_latch_cell #(
                .PULL_LEVEL(PULL_LEVELS[gi])
            ) u_cell (
                .clk_sys(clk_sys),
                .arst_n(arst_n),
                .sys_reset_active(sys_reset_active),
                .pin_in(pin_level[gi]),
                .pin_driven(pin_driven[gi]),
                .strap_bit(strap_vec[gi])
            );
        end
    endgenerate

    // Software registers
    logic [1:0] vsel_reg;
    logic [1:0] vsel_next;
    logic [7:0] pinctl_reg;
    logic [7:0] pinctl_next;

    // Write channel state
    logic [`STRAP_ADDR_W-1:0] waddr_reg;
    logic [`STRAP_ADDR_W-1:0] waddr_next;
    logic aw_have_reg;
    logic aw_have_next;
    logic [31:0] wdata_reg;
    logic [31:0] wdata_next;
    logic [3:0] wstrb_reg;
    logic [3:0] wstrb_next;
    logic w_have_reg;
    logic w_have_next;
    logic awready_reg;
    logic awready_next;
    logic wready_reg;
    logic wready_next;
    logic bvalid_reg;
    logic bvalid_next;
    logic [1:0] bresp_reg;
    logic [1:0] bresp_next;

    // Read channel state
    logic arready_reg;
    logic arready_next;
    logic rvalid_reg;
    logic rvalid_next;
    logic [31:0] rdata_reg;
    logic [31:0] rdata_next;
    logic [1:0] rresp_reg;
    logic [1:0] rresp_next;

    logic [31:0] status_word;
    logic [31:0] boot_word;
    logic supply_1v8_eff;

    always_comb begin
        status_word = 32'h0000_0000; // RULE_14
        status_word[`STRAP_BIT_BOOT] = straps.boot_sel; // RULE_14
        status_word[`STRAP_BIT_SUPPLY] = straps.supply_sel;
        status_word[`STRAP_BIT_PRINT] = straps.print_sel;
        // Firmware override wins over the strap once enabled
        supply_1v8_eff = vsel_reg[`VSEL_BIT_OVR_EN] ? vsel_reg[`VSEL_BIT_OVR_1V8] : straps.supply_sel; // RULE_10
        boot_word = 32'h0000_0000;
        boot_word[`BOOT_FLD_MODE_HI:`BOOT_FLD_MODE_LO] = decode_mode(straps);
        boot_word[`BOOT_BIT_PRINT_EN] = print_gate(fuse.print_ctrl, straps.print_sel);
        boot_word[`BOOT_BIT_ALT_PIN] = fuse.alt_print_pin;
        boot_word[`BOOT_BIT_FLASH_1V8] = supply_1v8_eff;
    end

    always_comb begin
        waddr_next = waddr_reg;
        aw_have_next = aw_have_reg;
        wdata_next = wdata_reg;
        wstrb_next = wstrb_reg;
        w_have_next = w_have_reg;
        bvalid_next = bvalid_reg;
        bresp_next = bresp_reg;
        vsel_next = vsel_reg;
        pinctl_next = pinctl_reg;
        if (s_axi_awvalid && awready_reg) begin
            waddr_next = s_axi_awaddr;
            aw_have_next = 1'b1;
        end
        if (s_axi_wvalid && wready_reg) begin
            wdata_next = s_axi_wdata;
            wstrb_next = s_axi_wstrb;
            w_have_next = 1'b1;
        end
        if (bvalid_reg && s_axi_bready) begin
            bvalid_next = 1'b0;
        end
        if (aw_have_reg && w_have_reg && !bvalid_reg) begin
            aw_have_next = 1'b0;
            w_have_next = 1'b0;
            bvalid_next = 1'b1;
            bresp_next = addr_mapped(waddr_reg) ? `AXI_RESP_OKAY : `AXI_RESP_SLVERR;
            // Status words are read-only; writes there are accepted and dropped
            if (wstrb_reg[0]) begin
                if (waddr_reg == `STRAP_OFF_VSEL) begin
                    vsel_next = wdata_reg[1:0];
                end
                if (waddr_reg == `STRAP_OFF_PINCTL) begin
                    pinctl_next = wdata_reg[7:0];
                end
            end
        end
        awready_next = !aw_have_next && !bvalid_next;
        wready_next = !w_have_next && !bvalid_next;
    end

    always_comb begin
        rvalid_next = rvalid_reg;
        rdata_next = rdata_reg;
        rresp_next = rresp_reg;
        if (rvalid_reg && s_axi_rready) begin
            rvalid_next = 1'b0;
        end
        if (s_axi_arvalid && arready_reg) begin
            rvalid_next = 1'b1;
            rresp_next = `AXI_RESP_OKAY;
            unique case (s_axi_araddr)
                `STRAP_OFF_STATUS: rdata_next = status_word; // RULE_02
                `STRAP_OFF_BOOT: rdata_next = boot_word;
                `STRAP_OFF_VSEL: rdata_next = {30'h0000_0000, vsel_reg};
                `STRAP_OFF_PINCTL: rdata_next = {24'h00_0000, pinctl_reg};
                default: begin
                    rdata_next = 32'h0000_0000;
                    rresp_next = `AXI_RESP_SLVERR;
                end
            endcase
        end
        arready_next = !rvalid_next;
    end

    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            waddr_reg <= '0;
            aw_have_reg <= 1'b0;
            wdata_reg <= 32'h0000_0000;
            wstrb_reg <= 4'h0;
            w_have_reg <= 1'b0;
            awready_reg <= 1'b0;
            wready_reg <= 1'b0;
            bvalid_reg <= 1'b0;
            bresp_reg <= `AXI_RESP_OKAY;
            vsel_reg <= `VSEL_RESET;
            pinctl_reg <= `PINCTL_RESET;
            arready_reg <= 1'b0;
            rvalid_reg <= 1'b0;
            rdata_reg <= 32'h0000_0000;
            rresp_reg <= `AXI_RESP_OKAY;
        end else begin
            waddr_reg <= waddr_next;
            aw_have_reg <= aw_have_next;
            wdata_reg <= wdata_next;
            wstrb_reg <= wstrb_next;
            w_have_reg <= w_have_next;
            awready_reg <= awready_next;
            wready_reg <= wready_next;
            bvalid_reg <= bvalid_next;
            bresp_reg <= bresp_next;
            vsel_reg <= vsel_next;
            pinctl_reg <= pinctl_next;
            arready_reg <= arready_next;
            rvalid_reg <= rvalid_next;
            rdata_reg <= rdata_next;
            rresp_reg <= rresp_next;
        end
    end

    // Boot side outputs and pin drive
    boot_mode_type mode_reg;
    boot_mode_type mode_next;
    logic print_en_reg;
    logic print_en_next;
    logic supply_reg;
    logic supply_next;
    logic primary_tx_reg;
    logic primary_tx_next;
    logic alt_tx_reg;
    logic alt_tx_next;
    logic [NUM_STRAPS-1:0] pin_out_reg;
    logic [NUM_STRAPS-1:0] pin_out_next;
    logic [NUM_STRAPS-1:0] pin_oe_reg;
    logic [NUM_STRAPS-1:0] pin_oe_next;

    always_comb begin
        mode_next = decode_mode(straps); // RULE_08
        print_en_next = print_gate(fuse.print_ctrl, straps.print_sel); // RULE_13
        supply_next = supply_1v8_eff; // RULE_10
        // Serial idles high; gated or redirected messages leave the other pin idle
        primary_tx_next = 1'b1;
        alt_tx_next = 1'b1;
        if (print_en_next) begin
            if (fuse.alt_print_pin) begin
                alt_tx_next = boot_msg_tx; // RULE_12
            end else begin
                primary_tx_next = boot_msg_tx; // RULE_12
            end
        end
        // Pins stay released during reset so the straps can be sampled
        if (sys_reset_active) begin
            pin_out_next = '0;
            pin_oe_next = '0;
        end else begin
            pin_out_next = pinctl_reg[`PINCTL_OUT_LO +: NUM_STRAPS]; // RULE_05
            pin_oe_next = pinctl_reg[`PINCTL_OE_LO +: NUM_STRAPS]; // RULE_05
        end
    end

    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            mode_reg <= BOOT_FLASH;
            print_en_reg <= 1'b0;
            supply_reg <= 1'b0;
            primary_tx_reg <= 1'b1;
            alt_tx_reg <= 1'b1;
            pin_out_reg <= '0;
            pin_oe_reg <= '0;
        end else begin
            mode_reg <= mode_next;
            print_en_reg <= print_en_next;
            supply_reg <= supply_next;
            primary_tx_reg <= primary_tx_next;
            alt_tx_reg <= alt_tx_next;
            pin_out_reg <= pin_out_next;
            pin_oe_reg <= pin_oe_next;
        end
    end

    assign boot_mode = mode_reg;
    assign boot_print_en = print_en_reg;
    assign flash_supply_1v8 = supply_reg;
    assign primary_serial_tx_pin = primary_tx_reg;
    assign alt_serial_tx_pin = alt_tx_reg;
    assign boot_select_pin_out = pin_out_reg[0];
    assign supply_select_pin_out = pin_out_reg[1];
    assign print_select_pin_out = pin_out_reg[2];
    assign boot_select_pin_oe = pin_oe_reg[0];
    assign supply_select_pin_oe = pin_oe_reg[1];
    assign print_select_pin_oe = pin_oe_reg[2];

    assign s_axi_awready = awready_reg;
    assign s_axi_wready = wready_reg;
    assign s_axi_bvalid = bvalid_reg;
    assign s_axi_bresp = bresp_reg;
    assign s_axi_arready = arready_reg;
    assign s_axi_rvalid = rvalid_reg;
    assign s_axi_rdata = rdata_reg;
    assign s_axi_rresp = rresp_reg;

endmodule

// ---- tb/strap_sva.sv ----
// Assertion checker for the strap latch block
`timescale 1ns/1ps
module strap_sva
    import strap_pkg::*;
(
    input wire logic clk_sys,
    input wire logic arst_n,
    input wire logic sys_reset_active,
    input wire logic boot_select_pin_in,
    input wire logic boot_select_pin_driven,
    input wire logic boot_select_pin_oe,
    input wire logic supply_select_pin_in,
    input wire logic supply_select_pin_driven,
    input wire logic supply_select_pin_oe,
    input wire logic print_select_pin_in,
    input wire logic print_select_pin_driven,
    input wire logic print_select_pin_oe,
    input wire fuse_type fuse,
    input wire logic boot_msg_tx,
    input wire logic primary_serial_tx_pin,
    input wire logic alt_serial_tx_pin,
    input wire boot_mode_type boot_mode,
    input wire logic boot_print_en,
    input wire logic flash_supply_1v8,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic s_axi_rvalid
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!arst_n);
    property p_oe_off;
        sys_reset_active |=> !(boot_select_pin_oe || supply_select_pin_oe || print_select_pin_oe);
    endproperty
    a_oe_off: assert property (p_oe_off) else $error("pin driven during reset");
    property p_hold;
        !sys_reset_active [*3] |-> $stable(boot_mode);
    endproperty
    a_hold: assert property (p_hold) else $error("boot mode moved outside reset");
    property p_flash;
        (sys_reset_active && (!boot_select_pin_driven || boot_select_pin_in)) ##1 !sys_reset_active
            |=> boot_mode == BOOT_FLASH;
    endproperty
    a_flash: assert property (p_flash) else $error("flash boot not decoded");
    property p_dl;
        (sys_reset_active && boot_select_pin_driven && !boot_select_pin_in
            && !(print_select_pin_driven && print_select_pin_in)) ##1 !sys_reset_active
            |=> boot_mode == BOOT_DOWNLOAD;
    endproperty
    a_dl: assert property (p_dl) else $error("download boot not decoded");
    property p_sup;
        (sys_reset_active && supply_select_pin_driven && supply_select_pin_in) ##1 !sys_reset_active
            |=> flash_supply_1v8;
    endproperty
    a_sup: assert property (p_sup) else $error("supply select high not 1.8 V");
    property p_sup_dflt;
        (sys_reset_active && !supply_select_pin_driven) ##1 !sys_reset_active |=> !flash_supply_1v8;
    endproperty
    a_sup_dflt: assert property (p_sup_dflt) else $error("floating supply select not 3.3 V");
    property p_never;
        fuse.print_ctrl == 2'h3 [*2] |-> !boot_print_en;
    endproperty
    a_never: assert property (p_never) else $error("printing with gate value 3");
    property p_always;
        fuse.print_ctrl == 2'h0 [*2] |-> boot_print_en;
    endproperty
    a_always: assert property (p_always) else $error("no printing with gate value 0");
    property p_tx;
        (boot_print_en && !fuse.alt_print_pin) [*3] |-> primary_serial_tx_pin == $past(boot_msg_tx)
            && alt_serial_tx_pin;
    endproperty
    a_tx: assert property (p_tx) else $error("boot stream not on primary pin");
    property p_quiet;
        !boot_print_en [*2] |-> primary_serial_tx_pin && alt_serial_tx_pin;
    endproperty
    a_quiet: assert property (p_quiet) else $error("serial pins not idle");
    property p_rd;
        s_axi_arvalid && s_axi_arready |=> s_axi_rvalid;
    endproperty
    a_rd: assert property (p_rd) else $error("read not answered");
endmodule

bind strap_pin_latch_boot_select strap_sva u_sva (.clk_sys, .arst_n, .sys_reset_active, .boot_select_pin_in,
    .boot_select_pin_driven, .boot_select_pin_oe, .supply_select_pin_in, .supply_select_pin_driven,
    .supply_select_pin_oe, .print_select_pin_in, .print_select_pin_driven, .print_select_pin_oe, .fuse,
    .boot_msg_tx, .primary_serial_tx_pin, .alt_serial_tx_pin, .boot_mode, .boot_print_en, .flash_supply_1v8,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid);

// ---- tb/strap_host_model.sv ----
// Pull resistors or host GPIO on the three strap pins
`timescale 1ns/1ps
module strap_host_model (
    input wire logic clk_sys,
    input wire logic [2:0] hold_en,
    input wire logic [2:0] hold_lvl,
    input wire logic [2:0] dev_out,
    input wire logic [2:0] dev_oe,
    output logic [2:0] pin_lvl,
    output logic [2:0] pin_drv
);
    logic wobble = 1'b0;
    // Released lines change every cycle, never show a stale level
    always @(posedge clk_sys) wobble <= !wobble;
    // Bench holds levels for the whole reset pulse
    always_comb begin
        pin_drv = hold_en;
        // Print high with boot low is never offered
        pin_drv[2] = hold_en[2] && !(hold_lvl[2] && hold_en[0] && !hold_lvl[0]);
        for (int i = 0; i < 3; i++) begin
            pin_lvl[i] = dev_oe[i] ? dev_out[i] : (pin_drv[i] ? hold_lvl[i] : wobble);
        end
    end
endmodule

// ---- tb/test_strap_pin_latch_boot_select.sv ----
// Self-checking bench for the strap latch block
`timescale 1ns/1ps
`include "strap_map.svh"
module test_strap_pin_latch_boot_select
    import strap_pkg::*;
;
    localparam logic [2:0] LV [6] = '{3'h0, 3'h7, 3'h5, 3'h0, 3'h1, 3'h3};
    localparam logic [1:0] CT [6] = '{2'h0, 2'h1, 2'h2, 2'h3, 2'h2, 2'h1};
    logic clk_sys, arst_n, srst, tx, prim, alt, pen, v18;
    logic [2:0] hold_en, hold_lvl, pin_lvl, pin_drv;
    wire logic [2:0] dev_out, dev_oe;
    fuse_type fuse;
    boot_mode_type mode;
    logic [3:0] awaddr, araddr, wstrb;
    logic [31:0] wdata, rdata;
    logic awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
    logic [1:0] bresp, rresp;
    int n_errors = 0;
    int cmp_count = 0;

    strap_host_model host (.clk_sys(clk_sys), .hold_en(hold_en), .hold_lvl(hold_lvl), .dev_out(dev_out),
        .dev_oe(dev_oe), .pin_lvl(pin_lvl), .pin_drv(pin_drv));
    strap_pin_latch_boot_select dut (.clk_sys(clk_sys), .arst_n(arst_n), .sys_reset_active(srst),
        .boot_select_pin_in(pin_lvl[0]), .boot_select_pin_driven(pin_drv[0]), .boot_select_pin_out(dev_out[0]),
        .boot_select_pin_oe(dev_oe[0]), .supply_select_pin_in(pin_lvl[1]),
        .supply_select_pin_driven(pin_drv[1]), .supply_select_pin_out(dev_out[1]),
        .supply_select_pin_oe(dev_oe[1]), .print_select_pin_in(pin_lvl[2]),
        .print_select_pin_driven(pin_drv[2]), .print_select_pin_out(dev_out[2]),
        .print_select_pin_oe(dev_oe[2]), .fuse(fuse), .boot_msg_tx(tx), .primary_serial_tx_pin(prim),
        .alt_serial_tx_pin(alt), .boot_mode(mode), .boot_print_en(pen), .flash_supply_1v8(v18),
        .s_axi_awaddr(awaddr), .s_axi_awprot(3'h0), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
        .s_axi_arprot(3'h0), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
        .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready));

    initial begin
        clk_sys = 1'b0;
        forever #2.5 clk_sys = !clk_sys;
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
        cmp_count++;
        if (got !== exp) begin
            n_errors++;
            $display("mismatch at %0t: %s", $time, m);
        end
    endtask

    task automatic wr(input logic [3:0] a, input logic [31:0] d, input logic [3:0] s, input logic [1:0] er);
        logic aw, w, done, ta, tw, tb;
        logic [1:0] r;
        int t;
        aw = 1'b1; w = 1'b1; done = 1'b0; t = 0; r = 2'h3;
        @(posedge clk_sys);
        awaddr <= a; wdata <= d; wstrb <= s; awvalid <= 1'b1; wvalid <= 1'b1; bready <= 1'b1;
        while (!done && t < 50) begin
            @(negedge clk_sys);
            ta = aw && awready; tw = w && wready; tb = bvalid === 1'b1; r = bresp;
            @(posedge clk_sys);
            if (ta) begin awvalid <= 1'b0; aw = 1'b0; end
            if (tw) begin wvalid <= 1'b0; w = 1'b0; end
            if (tb) begin bready <= 1'b0; done = 1'b1; end
            t++;
        end
        chk({30'h0, r}, {30'h0, er}, "write response");
    endtask

    task automatic rd(input logic [3:0] a, input logic [31:0] exp, input logic [1:0] er);
        logic done, ta;
        logic [1:0] r;
        logic [31:0] v;
        int t;
        done = 1'b0; t = 0; r = 2'h3; v = 32'hdead_beef;
        @(posedge clk_sys);
        araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
        while (!done && t < 50) begin
            @(negedge clk_sys);
            ta = arvalid && arready === 1'b1;
            if (rvalid === 1'b1) begin done = 1'b1; v = rdata; r = rresp; end
            @(posedge clk_sys);
            if (ta) arvalid <= 1'b0;
            if (done) rready <= 1'b0;
            t++;
        end
        chk({30'h0, r}, {30'h0, er}, "read response");
        chk(v, exp, "read data");
    endtask

    task automatic strap(input logic [2:0] en, input logic [2:0] lvl);
        @(posedge clk_sys);
        hold_en <= en; hold_lvl <= lvl; srst <= 1'b1;
        repeat (3) @(posedge clk_sys);
        srst <= 1'b0; hold_en <= 3'h0;
        repeat (3) @(posedge clk_sys);
    endtask

    task automatic t_defaults();
        fuse <= 3'h0;
        strap(3'h0, 3'h0);
        rd(`STRAP_OFF_STATUS, 32'h0000_0001, `AXI_RESP_OKAY);
        rd(`STRAP_OFF_BOOT, 32'h0000_0004, `AXI_RESP_OKAY);
        $display("test defaults done");
    endtask

    task automatic t_table();
        logic pe;
        for (int i = 0; i < 6; i++) begin
            pe = CT[i] == 2'h0 || (CT[i] == 2'h1 && !LV[i][2]) || (CT[i] == 2'h2 && LV[i][2]);
            fuse <= {CT[i], 1'b0};
            strap(3'h7, LV[i]);
            #1;
            chk({31'h0, pe}, {31'h0, pen}, "print gate");
            chk({31'h0, v18}, {31'h0, LV[i][1]}, "flash supply");
            rd(`STRAP_OFF_STATUS, {29'h0, LV[i]}, `AXI_RESP_OKAY);
            rd(`STRAP_OFF_BOOT, {27'h0, LV[i][1], 1'b0, pe, 1'b0, !LV[i][0]}, `AXI_RESP_OKAY);
        end
        $display("test strap table done");
    endtask

    task automatic t_hold();
        wr(`STRAP_OFF_PINCTL, 32'h0000_0075, 4'hf, `AXI_RESP_OKAY);
        rd(`STRAP_OFF_PINCTL, 32'h0000_0075, `AXI_RESP_OKAY);
        #1;
        chk({29'h0, dev_oe}, 32'h0000_0007, "pin enables");
        chk({29'h0, dev_out}, 32'h0000_0005, "pin outputs");
        rd(`STRAP_OFF_STATUS, 32'h0000_0003, `AXI_RESP_OKAY);
        wr(`STRAP_OFF_PINCTL, 32'h0000_0000, 4'hf, `AXI_RESP_OKAY);
        $display("test hold done");
    endtask

    task automatic t_regs();
        strap(3'h7, 3'h3);
        wr(`STRAP_OFF_STATUS, 32'hffff_ffff, 4'hf, `AXI_RESP_OKAY);
        rd(`STRAP_OFF_STATUS, 32'h0000_0003, `AXI_RESP_OKAY);
        wr(`STRAP_OFF_BOOT, 32'hffff_ffff, 4'hf, `AXI_RESP_OKAY);
        rd(`STRAP_OFF_BOOT, 32'h0000_0014, `AXI_RESP_OKAY);
        wr(`STRAP_OFF_VSEL, 32'h0000_0001, 4'hf, `AXI_RESP_OKAY);
        rd(`STRAP_OFF_BOOT, 32'h0000_0004, `AXI_RESP_OKAY);
        chk({31'h0, v18}, 32'h0000_0000, "override to 3.3 V");
        wr(`STRAP_OFF_VSEL, 32'h0000_0000, 4'h0, `AXI_RESP_OKAY);
        rd(`STRAP_OFF_VSEL, 32'h0000_0001, `AXI_RESP_OKAY);
        wr(4'h2, 32'h0000_0001, 4'hf, `AXI_RESP_SLVERR);
        rd(4'h2, 32'h0000_0000, `AXI_RESP_SLVERR);
        wr(`STRAP_OFF_VSEL, 32'h0000_0000, 4'hf, `AXI_RESP_OKAY);
        #1;
        chk({31'h0, v18}, 32'h0000_0001, "override off");
        $display("test registers done");
    endtask

    task automatic t_tx();
        @(posedge clk_sys);
        fuse <= 3'h0; tx <= 1'b0;
        repeat (3) @(posedge clk_sys);
        #1;
        chk({30'h0, prim, alt}, 32'h0000_0001, "primary pin stream");
        @(posedge clk_sys);
        fuse <= 3'h1;
        repeat (3) @(posedge clk_sys);
        #1;
        chk({30'h0, prim, alt}, 32'h0000_0002, "alternate pin stream");
        @(posedge clk_sys);
        fuse <= 3'h7;
        repeat (3) @(posedge clk_sys);
        #1;
        chk({30'h0, prim, alt}, 32'h0000_0003, "printing gated off");
        $display("test serial done");
    endtask

    task automatic tally_and_finish();
        $display("counts: %0d compares, %0d mismatches", cmp_count, n_errors);
        if (n_errors == 0 && cmp_count > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    initial begin
        #100000;
        n_errors++;
        tally_and_finish();
    end

    initial begin
        arst_n = 1'b0; srst = 1'b0; hold_en = 3'h0; hold_lvl = 3'h0; fuse = 3'h0; tx = 1'b1;
        awaddr = 4'h0; araddr = 4'h0; wdata = 32'h0000_0000; wstrb = 4'h0;
        awvalid = 1'b0; wvalid = 1'b0; bready = 1'b0; arvalid = 1'b0; rready = 1'b0;
        repeat (5) @(posedge clk_sys);
        arst_n <= 1'b1;
        t_defaults();
        t_table();
        t_hold();
        t_regs();
        t_tx();
        tally_and_finish();
    end
endmodule
